// ---- rtl/irq_l1_ctrl.sv ----
// Interrupt status, extended cause and layer-1 command register block on Wishbone
// What this block does
// - Eight-bit status register, fixed bit order
// - Second status shows timer recovery, waiting acknowledge
// - Extended bit summarises separate cause register
// - Receive data overflow flagged distinctly
// - Aborted received frame flagged
// - Transmit underrun flagged
// - Transmit repeat request flagged
// - Each layer-1 indication change raises channel change
// - Pool full at 32 bytes of open frame
// - Timer interrupt only in automatic mode
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`default_nettype none
module irq_l1_ctrl
  import irq_l1_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Events and levels from the HDLC and layer-1 parts
  input wire event_t events_i,
  input wire level_t levels_i,
  // Layer-1 control
  output logic [CI_WIDTH-1:0] ci_command_o,
  output logic software_power_up_o,
  output logic [ARB_WIDTH-1:0] bus_access_arbitration_o,
  output logic auto_mode_o,
  // Interrupt line
  output logic irq_o
);

  // Register state
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [7:1] stat_q, stat_d;
  logic [EXT_WIDTH-1:0] ext_q, ext_d;
  logic [CI_WIDTH-1:0] ci_cmd_q, ci_cmd_d;
  logic [CI_WIDTH-1:0] ci_prev_q, ci_prev_d;
  logic spu_q, spu_d;
  logic auto_q, auto_d;
  logic [ARB_WIDTH-1:0] arb_q, arb_d;
  logic pool_q, pool_d;
  logic irq_q, irq_d;

  // Bus decode; a request is taken when ack is low, a write lands at the ack edge
  logic take, wr, lane0, lane1;
  logic pool_now;
  logic [EXT_WIDTH-1:0] ext_set;
  logic [7:1] stat_set;
  logic [7:0] status_view;

  assign take = wb_cyc_i && wb_stb_i && !ack_q;
  // Write applied at the edge where the master samples ack, while it still holds the request
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign lane0 = wb_sel_i[0];
  assign lane1 = wb_sel_i[1];
  // Pool condition: a frame still open with a full pool waiting
  assign pool_now = levels_i.rx_frame_open && (levels_i.rx_level >= RX_POOL_BYTES);
  // Extended bit is the live OR of the causes, so it cannot go stale
  assign status_view = {stat_q, |ext_q};

  // Event sources for the extended cause register
  always_comb
  begin
    ext_set = '0;
    ext_set[EXT_SYNC_OVERFLOW] = events_i.sync_overflow;
    ext_set[EXT_MONITOR_STATUS] = events_i.monitor_status;
    ext_set[EXT_SUBSCRIBER_AWAKE] = events_i.subscriber_awake;
    ext_set[EXT_WATCHDOG_OVERFLOW] = events_i.watchdog_overflow;
    ext_set[EXT_PROTOCOL_ERROR] = events_i.protocol_error;
    ext_set[EXT_RX_DATA_OVERFLOW] = events_i.rx_data_overflow;
    ext_set[EXT_RX_ABORTED] = events_i.rx_aborted;
    ext_set[EXT_TX_UNDERRUN] = events_i.tx_underrun;
    ext_set[EXT_TX_REPEAT] = events_i.tx_repeat;
  end

  // Event sources for the main status register
  always_comb
  begin
    stat_set = '0;
    stat_set[BIT_RX_MSG_END] = events_i.rx_msg_end;
    stat_set[BIT_RX_POOL_FULL] = pool_now && !pool_q;
    stat_set[BIT_REMOTE_RX_CHANGE] = events_i.remote_rx_change;
    stat_set[BIT_TX_POOL_READY] = events_i.tx_pool_ready;
    // Timer expiry is ignored outside automatic mode
    stat_set[BIT_TIMER_EXPIRED] = events_i.timer_expired && auto_q;
    stat_set[BIT_CHANNEL_CHANGE] = levels_i.ci_indication != ci_prev_q;
    stat_set[BIT_SYNC_TRANSFER] = events_i.sync_transfer;
  end

  // Status next state: write-one-to-clear, a set in the same cycle wins
  always_comb
  begin
    stat_d = stat_q;
    ext_d = ext_q;
    if (wr && wb_adr_i == OFS_INT_ACK && lane0)
    begin
      stat_d = stat_q & ~wb_dat_i[7:1];
    end
    if (wr && wb_adr_i == OFS_EXT_CAUSE)
    begin
      if (lane0)
      begin
        ext_d[7:0] = ext_q[7:0] & ~wb_dat_i[7:0];
      end
      if (lane1)
      begin
        ext_d[8] = ext_q[8] & ~wb_dat_i[8];
      end
    end
    stat_d = stat_d | stat_set;
    ext_d = ext_d | ext_set;
    pool_d = pool_now;
    ci_prev_d = levels_i.ci_indication;
    // Output follows the status as it will stand next cycle
    irq_d = (|stat_d) || (|ext_d);
  end

  // Control registers written by the host
  always_comb
  begin
    ci_cmd_d = ci_cmd_q;
    spu_d = spu_q;
    auto_d = auto_q;
    arb_d = arb_q;
    if (wr && lane0)
    begin
      unique case (wb_adr_i)
        OFS_CI_COMMAND: ci_cmd_d = wb_dat_i[CI_WIDTH-1:0];
        OFS_SERIAL_PORT_CONTROL: spu_d = wb_dat_i[BIT_SOFT_POWER_UP];
        OFS_MODE_CONTROL:
        begin
          auto_d = wb_dat_i[BIT_AUTO_MODE];
          arb_d = wb_dat_i[ARB_ADDR_LSB +: ARB_WIDTH];
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses answer with zero
  always_comb
  begin
    ack_d = take;
    dat_d = '0;
    if (take && !wb_we_i)
    begin
      unique case (wb_adr_i)
        OFS_INT_STATUS: dat_d[7:0] = status_view;
        OFS_EXT_CAUSE: dat_d[EXT_WIDTH-1:0] = ext_q;
        OFS_SECOND_STATUS:
        begin
          dat_d[BIT_TIMER_RECOVERY] = levels_i.timer_recovery;
          dat_d[BIT_WAIT_ACK] = levels_i.wait_ack;
        end
        OFS_CI_COMMAND: dat_d[CI_WIDTH-1:0] = ci_cmd_q;
        OFS_CI_INDICATION: dat_d[CI_WIDTH-1:0] = ci_prev_q;
        OFS_SERIAL_PORT_CONTROL: dat_d[BIT_SOFT_POWER_UP] = spu_q;
        OFS_MODE_CONTROL:
        begin
          dat_d[BIT_AUTO_MODE] = auto_q;
          dat_d[ARB_ADDR_LSB +: ARB_WIDTH] = arb_q;
        end
        default: dat_d = '0;
      endcase
    end
  end

  // All state registered here
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
      stat_q <= INT_STATUS_RESET[7:1];
      ext_q <= '0;
      ci_cmd_q <= CI_COMMAND_RESET;
      ci_prev_q <= '0;
      spu_q <= 1'b0;
      auto_q <= 1'b0;
      arb_q <= ARB_ADDR_RESET;
      pool_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      stat_q <= stat_d;
      ext_q <= ext_d;
      ci_cmd_q <= ci_cmd_d;
      ci_prev_q <= ci_prev_d;
      spu_q <= spu_d;
      auto_q <= auto_d;
      arb_q <= arb_d;
      pool_q <= pool_d;
      irq_q <= irq_d;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign ci_command_o = ci_cmd_q;
  assign software_power_up_o = spu_q;
  assign auto_mode_o = auto_q;
  assign bus_access_arbitration_o = arb_q;
  assign irq_o = irq_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_status_read;
    take && !wb_we_i && wb_adr_i == OFS_INT_STATUS;
  endsequence
  sequence s_level_change;
    levels_i.ci_indication != $past(levels_i.ci_indication);
  endsequence

  chk_rme_status_bit: assert property (
    events_i.rx_msg_end |=> stat_q[BIT_RX_MSG_END])
    else $error("message end did not set status bit 7");
  chk_status_readback: assert property (
    s_status_read |=> wb_ack_o && wb_dat_o[7:0] == $past(status_view))
    else $error("status read returned wrong value");
  chk_second_status: assert property (
    take && !wb_we_i && wb_adr_i == OFS_SECOND_STATUS
    |=> wb_dat_o[1:0] == $past({levels_i.wait_ack, levels_i.timer_recovery}))
    else $error("second status read mismatch");
  chk_ext_summary: assert property (
    status_view[BIT_EXTENDED] == (|ext_q))
    else $error("extended bit does not track cause register");
  chk_rdo_cause: assert property (
    events_i.rx_data_overflow |=> ext_q[EXT_RX_DATA_OVERFLOW] && status_view[BIT_EXTENDED])
    else $error("receive overflow not flagged");
  chk_rab_cause: assert property (
    events_i.rx_aborted |=> ext_q[EXT_RX_ABORTED])
    else $error("receive abort not flagged");
  chk_xdu_cause: assert property (
    events_i.tx_underrun |=> ext_q[EXT_TX_UNDERRUN])
    else $error("transmit underrun not flagged");
  chk_xmr_cause: assert property (
    events_i.tx_repeat |=> ext_q[EXT_TX_REPEAT])
    else $error("transmit repeat not flagged");
  chk_ci_change: assert property (
    s_level_change |-> ##1 stat_q[BIT_CHANNEL_CHANGE])
    else $error("indication change lost");
  chk_pool_full: assert property (
    pool_now && !pool_q |=> stat_q[BIT_RX_POOL_FULL])
    else $error("pool full not raised at threshold");
  chk_timer_gated: assert property (
    !auto_q && !stat_q[BIT_TIMER_EXPIRED] && !(wr && wb_adr_i == OFS_MODE_CONTROL)
    ##1 !auto_q |-> !stat_q[BIT_TIMER_EXPIRED])
    else $error("timer flag raised outside automatic mode");
  chk_irq_level: assert property (
    ##1 irq_o == ((|$past(stat_d)) || (|$past(ext_d))) && (irq_o == (|status_view)))
    else $error("interrupt line does not follow status");

endmodule : irq_l1_ctrl
`default_nettype wire

// ---- rtl/irq_l1_pkg.sv ----
// Package: register map, field positions, reset values and carriers of the status block
`default_nettype none
package irq_l1_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] OFS_INT_STATUS = 8'h00;
  localparam logic [7:0] OFS_INT_ACK = 8'h04;
  localparam logic [7:0] OFS_EXT_CAUSE = 8'h08;
  localparam logic [7:0] OFS_SECOND_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CI_COMMAND = 8'h10;
  localparam logic [7:0] OFS_CI_INDICATION = 8'h14;
  localparam logic [7:0] OFS_SERIAL_PORT_CONTROL = 8'h18;
  localparam logic [7:0] OFS_MODE_CONTROL = 8'h1c;
  // Interrupt status bit positions
  localparam int BIT_RX_MSG_END = 7;
  localparam int BIT_RX_POOL_FULL = 6;
  localparam int BIT_REMOTE_RX_CHANGE = 5;
  localparam int BIT_TX_POOL_READY = 4;
  localparam int BIT_TIMER_EXPIRED = 3;
  localparam int BIT_CHANNEL_CHANGE = 2;
  localparam int BIT_SYNC_TRANSFER = 1;
  localparam int BIT_EXTENDED = 0;
  // Extended cause bit positions
  localparam int EXT_SYNC_OVERFLOW = 0;
  localparam int EXT_MONITOR_STATUS = 1;
  localparam int EXT_SUBSCRIBER_AWAKE = 2;
  localparam int EXT_WATCHDOG_OVERFLOW = 3;
  localparam int EXT_PROTOCOL_ERROR = 4;
  localparam int EXT_RX_DATA_OVERFLOW = 5;
  localparam int EXT_RX_ABORTED = 6;
  localparam int EXT_TX_UNDERRUN = 7;
  localparam int EXT_TX_REPEAT = 8;
  localparam int EXT_WIDTH = 9;
  // Other field positions
  localparam int BIT_TIMER_RECOVERY = 0;
  localparam int BIT_WAIT_ACK = 1;
  localparam int BIT_SOFT_POWER_UP = 0;
  localparam int BIT_AUTO_MODE = 0;
  localparam int ARB_ADDR_LSB = 4;
  localparam int CI_WIDTH = 4;
  localparam int ARB_WIDTH = 3;
  // Receive pool threshold in bytes
  localparam logic [5:0] RX_POOL_BYTES = 6'h20;
  // Reset values
  localparam logic [7:0] INT_STATUS_RESET = 8'h00;
  localparam logic [CI_WIDTH-1:0] CI_COMMAND_RESET = 4'hf;
  localparam logic [ARB_WIDTH-1:0] ARB_ADDR_RESET = 3'h0;

  // One-cycle event pulses from the HDLC and layer-1 parts
  typedef struct packed {
    logic rx_msg_end;
    logic remote_rx_change;
    logic tx_pool_ready;
    logic timer_expired;
    logic sync_transfer;
    logic sync_overflow;
    logic monitor_status;
    logic subscriber_awake;
    logic watchdog_overflow;
    logic protocol_error;
    logic rx_data_overflow;
    logic rx_aborted;
    logic tx_underrun;
    logic tx_repeat;
  } event_t;

  // Level status from the HDLC and layer-1 parts
  typedef struct packed {
    logic [5:0] rx_level;
    logic rx_frame_open;
    logic timer_recovery;
    logic wait_ack;
    logic [CI_WIDTH-1:0] ci_indication;
  } level_t;
endpackage : irq_l1_pkg
`default_nettype wire

// ---- verif/irq_l1_host.sv ----
// Host model: bus master and layer-1 driver sequences
`default_nettype none
module irq_l1_host
  import irq_l1_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Bus master side
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  // Set when an answer never came
  output logic hang_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o, hang_o} = '0;

  // One classic cycle, held until ack is sampled high or 64 clocks pass
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    logic got;
    got = 1'b0;
    rd = '0;
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= {2'b11, we, a, 4'hf, wd};
    for (int n = 0; n < 64 && !got; n++)
    begin
      @(posedge clk_i);
      got = (wb_ack_i === 1'b1);
      rd = wb_dat_i;
    end
    {wb_cyc_o, wb_stb_o} <= 2'b00;
    if (!got)
      hang_o <= 1'b1;
    // Return off the edge so that callers see the registers settled
    @(negedge clk_i);
  endtask : xfer

  // Command a change unless the indication already shows it
  task automatic l1_request(input logic [3:0] code, input logic [3:0] done_ind);
    logic [31:0] d;
    xfer(1'b0, OFS_CI_INDICATION, 32'h0, d);
    if (d[3:0] !== done_ind)
      xfer(1'b1, OFS_CI_COMMAND, {28'h0, code}, d);
  endtask : l1_request

  // Clock power-up, skipped when clocks already run
  task automatic power_up(input logic [3:0] tim, input logic [3:0] pu_ind);
    logic [31:0] d;
    logic seen;
    seen = 1'b0;
    xfer(1'b0, OFS_CI_INDICATION, 32'h0, d);
    if (d[3:0] === pu_ind)
      return;
    xfer(1'b1, OFS_SERIAL_PORT_CONTROL, 32'h1, d);
    xfer(1'b1, OFS_CI_COMMAND, {28'h0, tim}, d);
    for (int n = 0; n < 32 && !seen; n++)
    begin
      xfer(1'b0, OFS_CI_INDICATION, 32'h0, d);
      seen = (d[3:0] === pu_ind);
    end
    // An indication that never came is a lost answer
    if (!seen)
      hang_o <= 1'b1;
    xfer(1'b1, OFS_SERIAL_PORT_CONTROL, 32'h0, d);
  endtask : power_up

  // Start-up: automatic mode off and arbitration address
  task automatic l1_init(input logic [2:0] arb);
    logic [31:0] d;
    xfer(1'b1, OFS_MODE_CONTROL, {25'h0, arb, 4'h0}, d);
  endtask : l1_init
endmodule : irq_l1_host
`default_nettype wire

// ---- verif/isdn_ctrl_irq_and_l1_control_test.sv ----
// Self-checking bench of the status and layer-1 control block
`default_nettype none
module isdn_ctrl_irq_and_l1_control_test
  import irq_l1_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  // Layer-1 codes: arbitrary bench values
  localparam logic [3:0] CODE_ACT = 4'h8;
  localparam logic [3:0] CODE_DEA = 4'h0;
  localparam logic [3:0] CODE_LOOP = 4'ha;
  localparam logic [3:0] CODE_TIM = 4'h1;
  localparam logic [3:0] IND_ACT = 4'hc;
  localparam logic [3:0] IND_DEA = 4'h3;
  localparam logic [3:0] IND_PU = 4'h7;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, irq, software_power_up, auto_m, hang;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [3:0] ci_cmd;
  logic [2:0] arb;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] d;
  event_t ev = '0;
  event_t e;
  level_t lv = '0;
  int err_count = 0;
  int compares = 0;
  int seed = 32'h0664;
  int j;

  irq_l1_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .events_i(ev), .levels_i(lv), .ci_command_o(ci_cmd),
    .software_power_up_o(software_power_up), .bus_access_arbitration_o(arb), .auto_mode_o(auto_m),
    .irq_o(irq));
  irq_l1_host i_host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack),
    .hang_o(hang));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // A lost answer ends the run as a failure
  always @(posedge clk_i)
    if (hang)
    begin
      err_count++;
      results();
    end

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Bus helpers through the host model
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
    i_host.xfer(1'b0, a, 32'h0, d);
    check(n, d, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_host.xfer(1'b1, a, v, d);
  endtask : wr

  // One-cycle event pulse, then time for the flag to land
  task automatic pulse(input event_t p);
    @(posedge clk_i);
    ev <= p;
    @(posedge clk_i);
    ev <= '0;
    @(posedge clk_i);
  endtask : pulse

  // Status bit per event field, top field first; causes sum into bit 0
  function automatic logic [7:0] exp_status(input int i);
    case (i)
      13: return 8'h80;
      12: return 8'h20;
      11: return 8'h10;
      10: return 8'h08;
      9: return 8'h02;
      default: return 8'h01;
    endcase
  endfunction : exp_status

  // Main sequence
  initial
  begin
    repeat (16)
      @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("irq_rst", irq, 1'b0);
    check("ci_rst", ci_cmd, CI_COMMAND_RESET);
    rd(OFS_INT_STATUS, INT_STATUS_RESET, "status_rst");
    rd(8'h20, 32'h0, "unmapped");
    e = '0;
    e.timer_expired = 1'b1;
    pulse(e);
    rd(OFS_INT_STATUS, 32'h0, "timer_off");
    wr(OFS_MODE_CONTROL, 32'h1);
    check("auto", auto_m, 1'b1);
    // Every event once, then random ones
    for (int k = 0; k < 30; k++)
    begin
      j = (k < 14) ? k : $unsigned($random(seed)) % 14;
      e = '0;
      e[j] = 1'b1;
      pulse(e);
      @(negedge clk_i);
      check("irq_set", irq, 1'b1);
      rd(OFS_INT_STATUS, exp_status(j), "status");
      if (j < 9)
        rd(OFS_EXT_CAUSE, 32'h100 >> j, "cause");
      wr((j < 9) ? OFS_EXT_CAUSE : OFS_INT_ACK, 32'h1ff);
      rd(OFS_INT_STATUS, 32'h0, "cleared");
      check("irq_clr", irq, 1'b0);
    end
    lv.rx_frame_open <= 1'b1;
    lv.rx_level <= 6'h1f;
    rd(OFS_INT_STATUS, 32'h0, "pool31");
    lv.rx_level <= 6'h20;
    rd(OFS_INT_STATUS, 32'h40, "pool32");
    wr(OFS_INT_ACK, 32'hfe);
    repeat (4)
    begin
      lv.ci_indication <= lv.ci_indication ^ (4'($random(seed)) | 4'h1);
      {lv.timer_recovery, lv.wait_ack} <= 2'($random(seed));
      rd(OFS_INT_STATUS, 32'h04, "ci_change");
      rd(OFS_SECOND_STATUS, {30'h0, lv.wait_ack, lv.timer_recovery}, "second");
      wr(OFS_INT_ACK, 32'hfe);
    end
    lv.ci_indication <= IND_DEA;
    i_host.l1_request(CODE_ACT, IND_ACT);
    check("act", ci_cmd, CODE_ACT);
    lv.ci_indication <= IND_ACT;
    i_host.l1_request(CODE_DEA, IND_DEA);
    check("dea", ci_cmd, CODE_DEA);
    i_host.l1_request(CODE_LOOP, 4'h0);
    check("loop", ci_cmd, CODE_LOOP);
    rd(OFS_INT_STATUS, 32'h04, "ci_follow");
    wr(8'h24, 32'h5);
    check("unmapped_wr", ci_cmd, CODE_LOOP);
    // Power-up: bit set with timing code, cleared after indication
    fork
      i_host.power_up(CODE_TIM, IND_PU);
      begin
        repeat (14)
          @(posedge clk_i);
        check("spu_on", software_power_up, 1'b1);
        check("tim", ci_cmd, CODE_TIM);
        lv.ci_indication <= IND_PU;
      end
    join
    check("spu_off", software_power_up, 1'b0);
    j = $random(seed);
    i_host.l1_init(3'(j));
    check("arb", arb, 3'(j));
    check("auto_off", auto_m, 1'b0);
    results();
  end
endmodule : isdn_ctrl_irq_and_l1_control_test
`default_nettype wire
